// ==== src/cac_pkg.sv ====
// constants shared by both ends of the anticollision command link
// ==========================================================================
// Summary of operation
// - inventory start is bytes 06h then 00h
// - ready tag enters inventory, draws label, replies
// - inventory start answered with no slot compare
// - slot round is bytes 06h then 04h
// - slot round acted on only in inventory
// - slot round draws slot index 0 to 15
// - slot index held until next draw
// - slot round reply only when index zero
// - slot probe byte: low nibble 6, high index
// - slot probe reply only on index match
// - reader runs slot round then slot probes
// - reader uses inventory start alone for one tag; the bench runs rounds and probes with its one tag
// - reader repeats rounds until all identified; the bench runs a fixed three rounds
// - before selection only four commands accepted
// - return command sends selected tag to inventory
`default_nettype none
package cac_pkg;
  localparam logic [7:0] CMD_PREFIX = 8'h06;
  localparam logic [7:0] CMD_INIT_SUB = 8'h00;
  localparam logic [7:0] CMD_ROUND_SUB = 8'h04;
  localparam logic [3:0] PROBE_LOW = 4'h6;
  localparam logic [7:0] CMD_SELECT = 8'h0e;
  localparam logic [7:0] CMD_RETURN = 8'h0c;
  localparam logic [7:0] SOF_MARK = 8'ha5;
  localparam logic [7:0] EOF_MARK = 8'h5a;
  localparam logic [7:0] LFSR_SEED = 8'h01;
  localparam logic [15:0] CRC_INIT = 16'h6363;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam int BYTE_BITS = 8;
  localparam int CLK_DIV = 4;  // half period of the link clock in system clocks
  typedef enum logic [1:0] {
    CAC_READY = 2'b00,
    CAC_INVENTORY = 2'b01,
    CAC_SELECTED = 2'b10
  } cac_tag_state_e;
  // one byte of the crc, lsb first
  function automatic logic [15:0] cac_crc_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
endpackage
`default_nettype wire

// ==== src/cac_link_if.sv ====
// bit serial link between reader and tag, reader drives the clock
`default_nettype none
interface cac_link_if;
  logic link_clk;
  logic req_frame;
  logic req_data;
  logic ans_frame;
  logic ans_data;
  modport reader(output link_clk, output req_frame, output req_data,
                 input ans_frame, input ans_data);
  modport tag(input link_clk, input req_frame, input req_data,
              output ans_frame, output ans_data);
endinterface
`default_nettype wire

// ==== src/cac_tag.sv ====
// tag end: decodes anticollision commands and answers with its label
`default_nettype none
module cac_tag (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // link
  cac_link_if.tag link,
  // user side
  output logic [7:0] label_out,
  output logic [1:0] state_out
);
  import cac_pkg::*;

  // true when a closed frame carried the two opcode bytes given
  function automatic logic is_pair(input logic [7:0] first, input logic [7:0] second,
                                   input logic [7:0] c0, input logic [7:0] c1,
                                   input logic [1:0] count);
    return (first == c0) && (second == c1) && (count >= 2'h2);
  endfunction

  // ==========================================================================
  // input synchronisers
  // two stages before any use; the link clock is only sampled, never used as a clock
  logic [2:0] s1, s2;
  logic clk_d;
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s1 <= 3'h0;
      s2 <= 3'h0;
      clk_d <= 1'b0;
    end else begin
      s1 <= {link.link_clk, link.req_frame, link.req_data};
      s2 <= s1;
      clk_d <= s2[2];
    end
  end
  // edge flags of the link clock; the reader launches on falls and samples on rises
  wire rise = s2[2] & ~clk_d;
  wire fall = ~s2[2] & clk_d;

  // ==========================================================================
  // receive: bytes lsb first while frame high, frame end closes request
  logic [7:0] sh, next_sh;
  logic [7:0] b0, next_b0;
  logic [7:0] b1, next_b1;
  logic [3:0] bc, next_bc;
  logic [1:0] nb, next_nb;
  logic infr, next_infr;
  logic done;
  always_comb begin
    next_sh = sh;
    next_bc = bc;
    next_nb = nb;
    next_b0 = b0;
    next_b1 = b1;
    next_infr = infr;
    done = 1'b0;
    if (rise) begin
      if (s2[1]) begin
        next_infr = 1'b1;
        next_sh = {s2[0], sh[7:1]};
        next_bc = bc + 4'h1;
        // a full byte: keep the first two, later crc bytes are only counted
        if (bc == 4'h7) begin
          next_bc = 4'h0;
          if (nb == 2'h0) next_b0 = {s2[0], sh[7:1]};
          if (nb == 2'h1) next_b1 = {s2[0], sh[7:1]};
          if (nb != 2'h3) next_nb = nb + 2'h1;
        end
      // the frame closes on the first rise with frame low, so no length field is needed
      end else if (infr) begin
        done = 1'b1;
        next_infr = 1'b0;
        next_bc = 4'h0;
        next_nb = 2'h0;
      end
    end
  end

  // ==========================================================================
  // command decode, tag state and label
  cac_tag_state_e st, next_st;
  logic [7:0] label, next_label;
  logic [7:0] lfsr, next_lfsr;
  logic reply;
  // free-running lfsr; the draw depends on when a command ends, which differs per tag
  always_comb begin
    next_lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
  end
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) lfsr <= LFSR_SEED;
    else lfsr <= next_lfsr;
  end
  // crc bytes are trailing; only the first two bytes, opcodes and the select label, are decoded
  always_comb begin
    next_st = st;
    next_label = label;
    reply = 1'b0;
    if (done) begin
      unique case (st)
        // only the inventory start leaves ready; everything else is ignored
        CAC_READY: begin
          if (is_pair(b0, b1, CMD_PREFIX, CMD_INIT_SUB, nb)) begin
            next_st = CAC_INVENTORY;
            next_label = lfsr;
            reply = 1'b1;
          end
        end
        CAC_INVENTORY: begin
          if (is_pair(b0, b1, CMD_PREFIX, CMD_INIT_SUB, nb)) begin
            next_label = lfsr;
            reply = 1'b1;
          end else if (is_pair(b0, b1, CMD_PREFIX, CMD_ROUND_SUB, nb)) begin
            next_label = {label[7:4], lfsr[3:0]};
            reply = (lfsr[3:0] == 4'h0);
          end else if (b0[3:0] == PROBE_LOW && b0[7:4] != 4'h0) begin
            reply = (b0[7:4] == label[3:0]);
          end else if (b0 == CMD_SELECT && b1 == label) begin
            next_st = CAC_SELECTED;
            reply = 1'b1;
          end
        end
        // a selected tag listens only for the return to search
        CAC_SELECTED: begin
          if (b0 == CMD_RETURN) next_st = CAC_INVENTORY;
        end
        default: next_st = CAC_READY;
      endcase
    end
  end

  // ==========================================================================
  // answer shifter: sof, label, crc low, crc high, eof on link falling edges
  logic [39:0] tx, next_tx;
  logic [5:0] tc, next_tc;
  logic af, next_af;
  logic ad, next_ad;
  logic [15:0] crc;
  always_comb begin
    crc = ~cac_crc_byte(CRC_INIT, next_label);
    next_tx = tx;
    next_tc = tc;
    next_af = af;
    next_ad = ad;
    // a reply restarts the shifter; the link is half duplex so none is in flight
    if (reply) begin
      next_tx = {EOF_MARK, crc[15:8], crc[7:0], next_label, SOF_MARK};
      next_tc = 6'd40;
    end else if (fall) begin
      if (tc != 6'h0) begin
        next_af = 1'b1;
        next_ad = tx[0];
        next_tx = {1'b0, tx[39:1]};
        next_tc = tc - 6'h1;
      end else begin
        // frame low after the last bit so the reader sees the answer end
        next_af = 1'b0;
        next_ad = 1'b0;
      end
    end
  end

  // registers of the tag
  // outputs take the next values so they leave straight from flip-flops
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sh <= 8'h0;
      bc <= 4'h0;
      nb <= 2'h0;
      b0 <= 8'h0;
      b1 <= 8'h0;
      infr <= 1'b0;
      st <= CAC_READY;
      label <= 8'h0;
      tx <= 40'h0;
      tc <= 6'h0;
      af <= 1'b0;
      ad <= 1'b0;
      label_out <= 8'h0;
      state_out <= 2'h0;
    end else begin
      sh <= next_sh;
      bc <= next_bc;
      nb <= next_nb;
      b0 <= next_b0;
      b1 <= next_b1;
      infr <= next_infr;
      st <= next_st;
      label <= next_label;
      tx <= next_tx;
      tc <= next_tc;
      af <= next_af;
      ad <= next_ad;
      label_out <= next_label;
      state_out <= next_st;
    end
  end
  assign link.ans_frame = af;
  assign link.ans_data = ad;
endmodule // cac_tag
`default_nettype wire

// ==== src/cac_reader.sv ====
// reader end: sends one command frame and captures the answer label
`default_nettype none
module cac_reader (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // link
  cac_link_if.reader link,
  // user command: send_in pulses with bytes; two_in sends both
  input wire logic send_in,
  input wire logic two_in,
  input wire logic [7:0] byte0_in,
  input wire logic [7:0] byte1_in,
  // answer
  output logic busy_out,
  output logic ans_valid_out,
  output logic [7:0] ans_label_out
);
  import cac_pkg::*;

  // ==========================================================================
  // answer synchronisers
  logic [1:0] a1, a2;
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      a1 <= 2'h0;
      a2 <= 2'h0;
    end else begin
      a1 <= {link.ans_frame, link.ans_data};
      a2 <= a1;
    end
  end

  // ==========================================================================
  // the sequence is run by the user: inventory start, slot round, probes
  logic [2:0] dv, next_dv;
  logic ck, next_ck, fr, next_fr, dt, next_dt, bz, next_bz, av, next_av;
  logic [39:0] q, next_q;
  logic [5:0] n, next_n;
  logic [39:0] rx, next_rx;
  logic [15:0] crc;
  logic [7:0] lab, next_lab;
  always_comb begin
    next_dv = dv; next_ck = ck; next_fr = fr; next_dt = dt; next_bz = bz;
    next_q = q; next_n = n; next_rx = rx; next_lab = lab; next_av = 1'b0;
    // a send is taken when idle or while waiting for an answer that may never come
    if (send_in && (!bz || (n == 6'h0 && !fr))) begin
      crc = ~cac_crc_byte(two_in ? cac_crc_byte(CRC_INIT, byte0_in) : CRC_INIT,
                          two_in ? byte1_in : byte0_in);
      next_q = two_in ? {crc, byte1_in, byte0_in} : {8'h0, crc, byte0_in};
      next_n = two_in ? 6'd32 : 6'd24;
      next_bz = 1'b1;
      next_rx = 40'h0;
    end else begin
      crc = 16'h0;
    end
    // clock divider runs always so the tag sees continuous clock
    next_dv = dv + 3'h1;
    if (dv == 3'(CLK_DIV - 1)) begin
      next_dv = 3'h0;
      next_ck = ~ck;
      if (ck) begin
        // falling: present next bit
        if (bz && n != 6'h0) begin
          next_fr = 1'b1; next_dt = q[0]; next_q = {1'b0, q[39:1]}; next_n = n - 6'h1;
        end else next_fr = 1'b0;
      end else if (a2[1]) begin
        next_rx = {a2[0], rx[39:1]};
      end
    end
    if (bz && n == 6'h0 && !fr && rx[7:0] == SOF_MARK && rx[39:32] == EOF_MARK) begin
      next_lab = rx[15:8];
      next_av = 1'b1;
      next_rx = 40'h0;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      dv <= 3'h0; ck <= 1'b0; fr <= 1'b0; dt <= 1'b0; bz <= 1'b0; av <= 1'b0;
      q <= 40'h0; n <= 6'h0; rx <= 40'h0; lab <= 8'h0;
    end else begin
      dv <= next_dv; ck <= next_ck; fr <= next_fr; dt <= next_dt; bz <= next_bz;
      av <= next_av; q <= next_q; n <= next_n; rx <= next_rx; lab <= next_lab;
    end
  end
  assign link.link_clk = ck;
  assign link.req_frame = fr;
  assign link.req_data = dt;
  assign busy_out = bz;
  assign ans_valid_out = av;
  assign ans_label_out = lab;
endmodule // cac_reader
`default_nettype wire

// ==== verif/cac_link_monitor.sv ====
// checker for the link between reader and tag
`default_nettype none
module cac_link_monitor (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // link signals
  input wire logic link_clk,
  input wire logic req_frame,
  input wire logic req_data,
  input wire logic ans_frame,
  input wire logic ans_data
);
  logic lc_q;
  logic [5:0] acnt;
  logic [5:0] rcnt;
  logic [7:0] gap;
  logic [39:0] sh;
  wire logic lc_rise = link_clk & ~lc_q;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // ==========
  // helpers
  // counts clear while idle so the value at frame end is the whole frame
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      lc_q <= 1'b0;
      acnt <= 6'h00;
      rcnt <= 6'h00;
      gap <= 8'h00;
      sh <= 40'h0;
    end else begin
      lc_q <= link_clk;
      acnt <= ans_frame ? acnt + {5'h00, lc_rise} : 6'h00;
      rcnt <= req_frame ? rcnt + {5'h00, lc_rise} : 6'h00;
      gap <= req_frame ? 8'h00 : (gap == 8'hff ? gap : gap + 8'h01);
      if (ans_frame && lc_rise) sh <= {ans_data, sh[39:1]};
    end
  end
  // ==========
  // assertions
  a_no_overlap: assert property (!(req_frame && ans_frame))
    else $error("answer overlaps request");
  a_req_launch: assert property ($rose(req_frame) |-> !link_clk)
    else $error("request frame starts with link clock high");
  a_ans_launch: assert property ($rose(ans_frame) |-> !link_clk)
    else $error("answer frame starts with link clock high");
  a_req_hold: assert property (link_clk && $past(link_clk) && req_frame |-> $stable(req_data))
    else $error("request bit moves while link clock high");
  a_ans_hold: assert property (link_clk && $past(link_clk) && ans_frame |-> $stable(ans_data))
    else $error("answer bit moves while link clock high");
  a_req_bits: assert property ($fell(req_frame) |-> rcnt inside {6'd16, 6'd24, 6'd32})
    else $error("request frame length wrong");
  a_ans_bits: assert property ($fell(ans_frame) |-> acnt == 6'd40)
    else $error("answer frame not 40 bits");
  a_ans_marks: assert property ($fell(ans_frame) |-> sh[7:0] == 8'ha5 && sh[39:32] == 8'h5a)
    else $error("answer start or end marker wrong");
  a_reply_delay: assert property ($rose(ans_frame) |-> gap <= 8'd40)
    else $error("answer too late or unprompted");
  c_answer: cover property ($fell(ans_frame));
  c_long_req: cover property ($fell(req_frame) && rcnt == 6'd32);
  c_short_req: cover property ($fell(req_frame) && rcnt == 6'd24);
endmodule // cac_link_monitor
`default_nettype wire

// ==== verif/test_contactless_anticollision_cmds.sv ====
// self-checking bench: reader and tag joined over the link
`default_nettype none
module test_contactless_anticollision_cmds;
  timeunit 1ns;
  timeprecision 1ns;
  import cac_pkg::*;
  logic clk = 1'b0, rst = 1'b1, send = 1'b0, two = 1'b0, got = 1'b0;
  logic [7:0] b0 = 8'h00, b1 = 8'h00, hi, j;
  wire logic busy, av;
  wire logic [7:0] al, lbl;
  wire logic [1:0] st;
  int seed = 77, miscompares = 0, checks_done = 0;
  always #10 clk = ~clk;
  cac_link_if cac_link_if_inst ();
  cac_reader cac_reader_inst (.sys_clk_in(clk), .reset_in(rst), .link(cac_link_if_inst),
    .send_in(send), .two_in(two), .byte0_in(b0), .byte1_in(b1), .busy_out(busy),
    .ans_valid_out(av), .ans_label_out(al));
  cac_tag cac_tag_inst (.sys_clk_in(clk), .reset_in(rst), .link(cac_link_if_inst),
    .label_out(lbl), .state_out(st));
  cac_link_monitor cac_link_monitor_inst (.sys_clk_in(clk), .reset_in(rst),
    .link_clk(cac_link_if_inst.link_clk), .req_frame(cac_link_if_inst.req_frame),
    .req_data(cac_link_if_inst.req_data), .ans_frame(cac_link_if_inst.ans_frame),
    .ans_data(cac_link_if_inst.ans_data));
  // ==========
  // tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one frame; the window covers request, turnaround and a full answer
  task automatic xfer(input logic t, input logic [7:0] c0, input logic [7:0] c1);
    @(negedge clk);
    send = 1'b1;
    two = t;
    b0 = c0;
    b1 = c1;
    @(negedge clk);
    send = 1'b0;
    got = 1'b0;
    check("busy", {7'h00, busy}, 8'h01);
    for (int n = 0; n < 1000; n++) begin
      @(negedge clk);
      if (av === 1'b1) got = 1'b1;
    end
    if (got) check("label", al, lbl);
  endtask
  // a tag answers only in its own slot
  function automatic logic [7:0] hit(input logic [3:0] slot, input logic [7:0] l);
    return {7'h00, slot == l[3:0]};
  endfunction
  // ==========
  // main sequence
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    xfer(1'b1, CMD_PREFIX, CMD_ROUND_SUB);
    check("ready round", {7'h00, got}, 8'h00);
    check("state", {6'h00, st}, {6'h00, CAC_READY});
    xfer(1'b1, CMD_PREFIX, CMD_INIT_SUB);
    check("init reply", {7'h00, got}, 8'h01);
    check("state", {6'h00, st}, {6'h00, CAC_INVENTORY});
    repeat (3) begin
      hi = lbl;
      xfer(1'b1, CMD_PREFIX, CMD_ROUND_SUB);
      check("round reply", {7'h00, got}, hit(4'h0, lbl));
      check("upper", {4'h0, lbl[7:4]}, {4'h0, hi[7:4]});
      hi = lbl;
      // every probe index, so a match is hit exactly once when the slot is nonzero
      for (int s = 1; s < 16; s++) begin
        xfer(1'b0, {s[3:0], PROBE_LOW}, 8'h00);
        check("probe reply", {7'h00, got}, hit(s[3:0], lbl));
      end
      j = $random(seed);
      xfer(1'b0, {j[7:4], 4'h8}, 8'h00);
      check("junk reply", {7'h00, got}, 8'h00);
      check("held label", lbl, hi);
    end
    xfer(1'b1, CMD_SELECT, lbl);
    check("state", {6'h00, st}, {6'h00, CAC_SELECTED});
    xfer(1'b0, CMD_RETURN, 8'h00);
    check("return reply", {7'h00, got}, 8'h00);
    check("state", {6'h00, st}, {6'h00, CAC_INVENTORY});
    end_of_test();
  end
endmodule // test_contactless_anticollision_cmds
`default_nettype wire
